// [hw/tsa_config.sv]
// System-area configuration decode, access checks, host wait timers and interrupt pin
// Behaviour
// - Lock bit plus RF read-only bit set RF access
// - RF read-only map: bit n byte k
// - Serial map bit one makes block read-only
// - All three maps default to zero
// - Lock map ignored on serial accesses
// - Protocol selector bits 5:4, 11 means default
// - Identifier source bit zero gives all-zero identifier
// - Slave address from bits 6:0, default 1010100
// - Query wait is T times 2^exponent
// - Query exponent above eight uses default
// - Answer wait, exponent 0..12, default seven
// - Inter-character wait, 942us base, default three
// - Response-start wait, 1.88ms base, default three
// - Select bits 2:1 choose extra RF interrupt
// - Select bit 0 adds field-detect interrupt
// - Command completion always interrupts the host
// - Select bits default zero: completion only
// - System code defaults AA then FF
// - Invalid enable or check byte gives defaults
// - Maps act now, others after reload
module tsa_config
  import tsa_pkg::*;
#(
  parameter int TUNNEL_BASE = TUNNEL_BASE_CYC,
  parameter int CHAR_BASE   = CHAR_BASE_CYC,
  parameter int RESP_BASE   = RESP_BASE_CYC
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_b,
  // System-area byte port from the memory controller
  input  wire logic [8:0]      sa_addr,
  input  wire logic            sa_wr,
  input  wire logic [7:0]      sa_wdata,
  output logic      [7:0]      sa_rdata,
  // Configuration validity and reload
  input  wire logic            cfg_valid,
  input  wire logic            self_reset,
  output tsa_hw_cfg_t          hw_cfg,
  // Access checks
  input  tsa_access_req_t      rf_req,
  output logic                 rf_grant,
  input  tsa_access_req_t      ser_req,
  output logic                 ser_grant,
  // Host-interface events and wait status
  input  tsa_host_evt_t        host_evt,
  output logic                 wait_timeout,
  output logic [4:0]           host_state,
  // Interrupt pin, open drain
  input  tsa_irq_src_t         irq_src,
  input  wire logic            irq_ack,
  output logic                 host_interrupt_request_n_o,
  output logic                 host_interrupt_request_n_oe
);

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_QUERY  = 5'h02,
    ST_ANSWER = 5'h04,
    ST_CHAR   = 5'h08,
    ST_RESP   = 5'h10
  } tsa_state_t;

  // Byte store of the system area, reset to the power-up defaults
  logic [7:0] sa_mem [SA_BYTES];
  logic [7:0] sa_rdata_r;

  // Pick one map bit for a block; reserved bits are picked too, but rf_mapped and ser_mapped discard them
  function automatic logic map_bit(input logic [31:0] map, input logic [4:0] blk);
    return map[blk];
  endfunction : map_bit

  // Grant RF access from lock and read-only bits
  function automatic logic rf_allow(input logic lock, input logic ro,
                                    input logic enc, input logic wr);
    logic ok;
    ok = 1'b1;
    if (!enc && !lock && ro) begin
      ok = 1'b0;                                 // Plaintext prohibited
    end else if (wr && lock && (!ro || !enc)) begin
      ok = 1'b0;                                 // Read-only cases
    end
    return ok;
  endfunction : rf_allow

  wire        in_area = (sa_addr >= SA_BASE);
  wire  [4:0] sa_idx  = sa_addr[4:0];

  // Byte writes; a write to an access map acts on the very next
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SA_BYTES; i++) begin
        sa_mem[i] <= 8'h00;                      // Maps zero
      end
      sa_mem[0] <= SYSTEM_CODE_D0_DEF;
      sa_mem[1] <= SYSTEM_CODE_D1_DEF;
      sa_mem[5'(HW_ONE_OFF - SA_BASE) + 5'd1] <= {1'b0, SLAVE_ADDR_DEF};
      sa_mem[5'(TUNNEL_OFF - SA_BASE)] <= {QWT_DEF, AWT_DEF};
      sa_mem[5'(HW_TWO_OFF - SA_BASE)] <= {INTERCHARACTER_WAIT_EXPONENT_DEF, RESPONSE_START_WAIT_EXPONENT_DEF, 1'b0, EXTRA_INTERRUPT_SELECT_DEF};
    end else if (sa_wr && in_area) begin
      sa_mem[sa_idx] <= sa_wdata;                // Reserved bits kept as written
    end
  end

  // Registered read; outside the system area reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sa_rdata_r <= 8'h00;
    end else begin
      sa_rdata_r <= in_area ? sa_mem[sa_idx] : 8'h00;
    end
  end
  assign sa_rdata = sa_rdata_r;

  // Raw fields of the stored bytes
  wire [7:0] hw1_b0 = sa_mem[5'(HW_ONE_OFF - SA_BASE)];
  wire [7:0] hw1_b1 = sa_mem[5'(HW_ONE_OFF - SA_BASE) + 5'd1];
  wire [7:0] tn_b   = sa_mem[5'(TUNNEL_OFF - SA_BASE)];
  wire [7:0] hw2_b  = sa_mem[5'(HW_TWO_OFF - SA_BASE)];
  wire [1:0] proto_raw = hw1_b0[PROTO_LSB +: 2];
  wire [3:0] qwt_raw   = tn_b[QWT_LSB +: 4];
  wire [3:0] awt_raw   = tn_b[AWT_LSB +: 4];

  // Effective values, falling back to defaults when the area is not enabled
  wire [1:0] proto_eff = (!cfg_valid || proto_raw == PROTO_RESERVED)
                         ? PROTO_DEF : proto_raw;
  wire       idsrc_eff = cfg_valid & hw1_b0[IDSRC_BIT];
  wire [6:0] addr_eff  = cfg_valid ? hw1_b1[6:0] : SLAVE_ADDR_DEF;
  wire [15:0] sc_eff   = cfg_valid ? {sa_mem[0], sa_mem[1]}
                         : {SYSTEM_CODE_D0_DEF, SYSTEM_CODE_D1_DEF};
  wire [3:0] qwt_eff   = (!cfg_valid || qwt_raw > QWT_MAX) ? QWT_DEF : qwt_raw;
  wire [3:0] awt_eff   = (!cfg_valid || awt_raw > AWT_MAX) ? AWT_DEF : awt_raw;
  wire [1:0] intercharacter_wait_exponent_eff = cfg_valid ? hw2_b[INTERCHARACTER_WAIT_EXPONENT_LSB +: 2] : INTERCHARACTER_WAIT_EXPONENT_DEF;
  wire [1:0] response_start_wait_exponent_eff = cfg_valid ? hw2_b[RESPONSE_START_WAIT_EXPONENT_LSB +: 2] : RESPONSE_START_WAIT_EXPONENT_DEF;
  wire [2:0] extra_interrupt_select_eff = cfg_valid ? hw2_b[EXTRA_INTERRUPT_SELECT_LSB +: 3] : EXTRA_INTERRUPT_SELECT_DEF;

  // Latched power-up values; rewrites wait for power-up or a self-reset
  logic        load_pend_r;
  tsa_hw_cfg_t hw_cfg_r;
  logic [3:0]  qwt_r;
  logic [3:0]  awt_r;
  logic [1:0]  intercharacter_wait_exponent_r;
  logic [1:0]  response_start_wait_exponent_r;
  logic [2:0]  extra_interrupt_select_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      load_pend_r <= 1'b1;
      hw_cfg_r    <= '{PROTO_DEF, 1'b0, SLAVE_ADDR_DEF,
                       {SYSTEM_CODE_D0_DEF, SYSTEM_CODE_D1_DEF}};
      qwt_r       <= QWT_DEF;
      awt_r       <= AWT_DEF;
      intercharacter_wait_exponent_r     <= INTERCHARACTER_WAIT_EXPONENT_DEF;
      response_start_wait_exponent_r     <= RESPONSE_START_WAIT_EXPONENT_DEF;
      extra_interrupt_select_r    <= EXTRA_INTERRUPT_SELECT_DEF;
    end else if (load_pend_r || self_reset) begin
      load_pend_r <= 1'b0;
      hw_cfg_r    <= '{proto_eff, idsrc_eff, addr_eff, sc_eff};
      qwt_r       <= qwt_eff;
      awt_r       <= awt_eff;
      intercharacter_wait_exponent_r     <= intercharacter_wait_exponent_eff;
      response_start_wait_exponent_r     <= response_start_wait_exponent_eff;
      extra_interrupt_select_r    <= extra_interrupt_select_eff;
    end
  end
  assign hw_cfg = hw_cfg_r;

  // Map words gathered whole, so a rewritten byte reaches the check at once
  wire [4:0]  rf_ro_idx  = 5'(RF_RO_OFF - SA_BASE);
  wire [4:0]  ser_ro_idx = 5'(SER_RO_OFF - SA_BASE);
  wire [4:0]  lock_idx   = 5'(LOCK_OFF - SA_BASE);
  wire [31:0] rf_ro_map  = {sa_mem[rf_ro_idx + 5'd3], sa_mem[rf_ro_idx + 5'd2],
                            sa_mem[rf_ro_idx + 5'd1], sa_mem[rf_ro_idx]};
  wire [31:0] ser_ro_map = {sa_mem[ser_ro_idx + 5'd3], sa_mem[ser_ro_idx + 5'd2],
                            sa_mem[ser_ro_idx + 5'd1], sa_mem[ser_ro_idx]};
  wire [31:0] lock_map   = {sa_mem[lock_idx + 5'd3], sa_mem[lock_idx + 5'd2],
                            sa_mem[lock_idx + 5'd1], sa_mem[lock_idx]};

  // Live access maps; a disabled area reads as all read/write
  wire rf_lock = cfg_valid & map_bit(lock_map, rf_req.block);
  wire rf_ro   = cfg_valid & map_bit(rf_ro_map, rf_req.block);
  wire ser_ro  = cfg_valid & map_bit(ser_ro_map, ser_req.block);
  wire rf_mapped  = (rf_req.block < 5'(MAP_BLOCKS));
  wire ser_mapped = (ser_req.block < 5'(MAP_BLOCKS));
  wire rf_ok  = !rf_mapped || rf_allow(rf_lock, rf_ro, rf_req.encrypted, rf_req.write);
  wire ser_ok = !ser_mapped || !(ser_req.write && ser_ro); // Lock map not consulted

  logic rf_grant_r;
  logic ser_grant_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rf_grant_r  <= 1'b0;
      ser_grant_r <= 1'b0;
    end else begin
      rf_grant_r  <= rf_req.valid & rf_ok;
      ser_grant_r <= ser_req.valid & ser_ok;
    end
  end
  assign rf_grant  = rf_grant_r;
  assign ser_grant = ser_grant_r;

  // Shared prescaler: one counter per base, advanced in one process.
  // A wait may start mid-period, so it can end up to one base early;
  // the base is only held to 25 percent anyway.
  logic [19:0] pre_tun_r;
  logic [19:0] pre_chr_r;
  logic [19:0] pre_rsp_r;
  wire tick_tun = (pre_tun_r == 20'(TUNNEL_BASE - 1));
  wire tick_chr = (pre_chr_r == 20'(CHAR_BASE - 1));
  wire tick_rsp = (pre_rsp_r == 20'(RESP_BASE - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_tun_r <= 20'h0;
      pre_chr_r <= 20'h0;
      pre_rsp_r <= 20'h0;
    end else begin
      pre_tun_r <= tick_tun ? 20'h0 : pre_tun_r + 20'h1;
      pre_chr_r <= tick_chr ? 20'h0 : pre_chr_r + 20'h1;
      pre_rsp_r <= tick_rsp ? 20'h0 : pre_rsp_r + 20'h1;
    end
  end

  // Host-interface wait machine
  tsa_state_t          state_r;
  tsa_state_t          state_nxt;
  logic [TICK_W-1:0]   ticks_r;
  logic [TICK_W-1:0]   limit;
  logic                tick;
  logic                restart;
  logic                timeout_r;

  always_comb begin
    state_nxt = state_r;
    restart   = 1'b0;
    limit     = TICK_W'(1);
    tick      = 1'b0;
    case (state_r)
      ST_QUERY: begin
        limit = TICK_W'(1) << qwt_r;
        tick  = tick_tun;
        if (host_evt.query_rcvd) state_nxt = ST_IDLE;
      end
      ST_ANSWER: begin
        limit = TICK_W'(1) << awt_r;
        tick  = tick_tun;
        if (host_evt.answer_rcvd) state_nxt = ST_IDLE;
      end
      ST_CHAR: begin
        limit = TICK_W'(1) << intercharacter_wait_exponent_r;
        tick  = tick_chr;
        restart = host_evt.host_char;
        if (host_evt.host_frame_end) state_nxt = ST_IDLE;
      end
      ST_RESP: begin
        limit = TICK_W'(1) << response_start_wait_exponent_r;
        tick  = tick_rsp;
        if (host_evt.slave_tx_req) state_nxt = ST_IDLE;
      end
      default: begin
        if (host_evt.tunnel_irq_raised) state_nxt = ST_QUERY;
        else if (host_evt.query_answered) state_nxt = ST_ANSWER;
        else if (host_evt.resp_started) state_nxt = ST_RESP;
        else if (host_evt.host_char) state_nxt = ST_CHAR;
      end
    endcase
    if (state_r == ST_QUERY && host_evt.query_answered) state_nxt = ST_ANSWER;
  end

  wire expire = (state_r != ST_IDLE) && tick && !restart
                && (ticks_r + TICK_W'(1) >= limit) && (state_nxt == state_r);

  // Expiry abandons the exchange
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      ticks_r   <= '0;
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= expire;
      state_r   <= expire ? ST_IDLE : state_nxt;
      if (expire || restart || state_nxt != state_r) ticks_r <= '0;
      else if (tick) ticks_r <= ticks_r + TICK_W'(1);
    end
  end
  assign wait_timeout = timeout_r;
  assign host_state   = state_r;

  // Interrupt sources: completion always, extras by selection
  wire xsel_pre = (extra_interrupt_select_r[2:1] == XIRQ_PRE_TX);
  wire xsel_wr  = (extra_interrupt_select_r[2:1] == XIRQ_WRITE_DONE);
  wire irq_set  = irq_src.cmd_done
                | (xsel_pre & irq_src.rf_pre_tx)
                | (xsel_wr & irq_src.rf_write_done)
                | (extra_interrupt_select_r[0] & irq_src.field_detect);

  // Pin pulled low while pending; a new event beats a same-cycle acknowledge
  logic irq_pend_r;
  logic irq_out_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend_r <= 1'b0;
      irq_out_r  <= 1'b0;
    end else begin
      irq_pend_r <= irq_set | (irq_pend_r & ~irq_ack);
      irq_out_r  <= 1'b0;
    end
  end
  assign host_interrupt_request_n_o  = irq_out_r;
  assign host_interrupt_request_n_oe = irq_pend_r;

endmodule : tsa_config

// [hw/tsa_pkg.sv]
// Shared constants and types for the tag system-area configuration block
package tsa_pkg;
  // System-area window, byte offsets
  localparam logic [8:0] SA_BASE        = 9'h1e0;
  localparam logic [8:0] SYSTEM_CODE_OFF = 9'h1e0;
  localparam logic [8:0] HW_ONE_OFF     = 9'h1ee;
  localparam logic [8:0] RF_RO_OFF      = 9'h1f0;
  localparam logic [8:0] SER_RO_OFF     = 9'h1f4;
  localparam logic [8:0] LOCK_OFF       = 9'h1f8;
  localparam logic [8:0] TUNNEL_OFF     = 9'h1fc;
  localparam logic [8:0] HW_TWO_OFF     = 9'h1fd;
  localparam int         SA_BYTES       = 32;
  localparam int         MAP_BLOCKS     = 27;

  // Field positions
  localparam int PROTO_LSB  = 4;
  localparam int IDSRC_BIT  = 0;
  localparam int QWT_LSB    = 4;
  localparam int AWT_LSB    = 0;
  localparam int INTERCHARACTER_WAIT_EXPONENT_LSB  = 6;
  localparam int RESPONSE_START_WAIT_EXPONENT_LSB  = 4;
  localparam int EXTRA_INTERRUPT_SELECT_LSB = 0;

  // Reset and default values
  localparam logic [7:0] SYSTEM_CODE_D0_DEF = 8'haa;
  localparam logic [7:0] SYSTEM_CODE_D1_DEF = 8'hff;
  localparam logic [1:0] PROTO_DEF          = 2'h0;
  localparam logic [1:0] PROTO_RESERVED     = 2'h3;
  localparam logic [6:0] SLAVE_ADDR_DEF     = 7'h54;
  localparam logic [3:0] QWT_DEF            = 4'h4;
  localparam logic [3:0] QWT_MAX            = 4'h8;
  localparam logic [3:0] AWT_DEF            = 4'h7;
  localparam logic [3:0] AWT_MAX            = 4'hc;
  localparam logic [1:0] INTERCHARACTER_WAIT_EXPONENT_DEF          = 2'h3;
  localparam logic [1:0] RESPONSE_START_WAIT_EXPONENT_DEF          = 2'h3;
  localparam logic [2:0] EXTRA_INTERRUPT_SELECT_DEF         = 3'h0;
  localparam logic [1:0] XIRQ_PRE_TX        = 2'h2;
  localparam logic [1:0] XIRQ_WRITE_DONE    = 2'h3;

  // Timing: base periods in ns, clock period in ns
  localparam int CLK_PERIOD_NS   = 4;
  localparam int TUNNEL_BASE_NS  = 1024000;
  localparam int CHAR_BASE_NS    = 942000;
  localparam int RESP_BASE_NS    = 1880000;
  localparam int TUNNEL_BASE_CYC = TUNNEL_BASE_NS / CLK_PERIOD_NS;
  localparam int CHAR_BASE_CYC   = CHAR_BASE_NS / CLK_PERIOD_NS;
  localparam int RESP_BASE_CYC   = RESP_BASE_NS / CLK_PERIOD_NS;
  localparam int TICK_W          = 13;

  // Memory access check request
  typedef struct packed {
    logic       valid;
    logic [4:0] block;
    logic       encrypted;
    logic       write;
  } tsa_access_req_t;

  // Host-interface events that start and stop the wait timers
  typedef struct packed {
    logic tunnel_irq_raised;
    logic query_rcvd;
    logic query_answered;
    logic answer_rcvd;
    logic host_char;
    logic host_frame_end;
    logic resp_started;
    logic slave_tx_req;
  } tsa_host_evt_t;

  // Interrupt sources
  typedef struct packed {
    logic cmd_done;
    logic rf_pre_tx;
    logic rf_write_done;
    logic field_detect;
  } tsa_irq_src_t;

  // Power-up configuration seen by the rest of the tag
  typedef struct packed {
    logic [1:0]  rf_protocol_select;
    logic        identifier_source_select;
    logic [6:0]  host_slave_address;
    logic [15:0] system_code_bytes;
  } tsa_hw_cfg_t;
endpackage : tsa_pkg

// [sim/tsa_config_asserts.sv]
// Concurrent checks on the ports of the configuration block
module tsa_config_asserts
  import tsa_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      rst_b,
  // Access checks
  input tsa_access_req_t rf_req,
  input wire logic      rf_grant,
  input tsa_access_req_t ser_req,
  input wire logic      ser_grant,
  // Wait machine
  input tsa_host_evt_t  host_evt,
  input wire logic      wait_timeout,
  input wire logic [4:0] host_state,
  // Interrupt pin
  input tsa_irq_src_t   irq_src,
  input wire logic      irq_ack,
  input wire logic      host_interrupt_request_n_o,
  input wire logic      host_interrupt_request_n_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Completion raises the pin, which then waits for the host
  sequence s_raise;
    irq_src.cmd_done ##1 (!irq_ack && irq_src == 4'h0);
  endsequence
  AST_NO_REQ: assert property (!rf_req.valid |=> !rf_grant)
    else $error("grant without request");
  AST_HIGH_BLOCK: assert property (rf_req.valid && rf_req.block > 5'd26 |=> rf_grant)
    else $error("system block refused");
  AST_SER_READ: assert property (ser_req.valid && !ser_req.write |=> ser_grant)
    else $error("serial read refused");
  AST_QUERY_ENTRY: assert property (host_state == 5'h01 && host_evt.tunnel_irq_raised
    |=> host_state == 5'h02)
    else $error("query wait not entered");
  AST_ONE_HOT: assert property ($onehot(host_state))
    else $error("host state not one-hot");
  AST_TMO_IDLE: assert property (wait_timeout && $past(host_evt) == 8'h00
    |-> host_state == 5'h01)
    else $error("timeout left machine busy");
  AST_TMO_PULSE: assert property (wait_timeout |=> !wait_timeout)
    else $error("timeout pulse too long");
  AST_CMD_IRQ: assert property (irq_src.cmd_done |=> host_interrupt_request_n_oe)
    else $error("completion did not interrupt");
  AST_IRQ_STAYS: assert property (s_raise |-> host_interrupt_request_n_oe)
    else $error("interrupt dropped before ack");
  AST_ACK_CLR: assert property (irq_ack && irq_src == 4'h0 |=> !host_interrupt_request_n_oe)
    else $error("ack did not clear");
  AST_PIN_LOW: assert property (!host_interrupt_request_n_o)
    else $error("pin drives high");
endmodule : tsa_config_asserts

bind tsa_config tsa_config_asserts i_chk (.mclk(mclk), .rst_b(rst_b), .rf_req(rf_req),
  .rf_grant(rf_grant), .ser_req(ser_req), .ser_grant(ser_grant), .host_evt(host_evt),
  .wait_timeout(wait_timeout), .host_state(host_state), .irq_src(irq_src), .irq_ack(irq_ack),
  .host_interrupt_request_n_o(host_interrupt_request_n_o),
  .host_interrupt_request_n_oe(host_interrupt_request_n_oe));

// [sim/tsa_config_test.sv]
// Self-checking bench for the configuration block
module tsa_config_test
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TB = 8;
  localparam int CB = 7;
  localparam int RB = 10;
  logic mclk = 0, rst_b = 0, sa_wr = 0, cfg_valid = 1, self_reset = 0, irq_ack;
  logic [8:0] sa_addr = '0;
  logic [7:0] sa_wdata = '0, sa_rdata;
  tsa_hw_cfg_t hw_cfg;
  tsa_access_req_t rf_req = '0, ser_req = '0;
  logic rf_grant, ser_grant, wait_timeout, pin_o, pin_oe;
  logic [4:0] host_state;
  tsa_host_evt_t host_evt = '0;
  tsa_irq_src_t irq_src = '0;
  int n_fail = 0, n_checks = 0;
  always #2 mclk = ~mclk;
  tsa_config #(.TUNNEL_BASE(TB), .CHAR_BASE(CB), .RESP_BASE(RB)) i_dut (.mclk(mclk),
    .rst_b(rst_b), .sa_addr(sa_addr), .sa_wr(sa_wr), .sa_wdata(sa_wdata), .sa_rdata(sa_rdata),
    .cfg_valid(cfg_valid), .self_reset(self_reset), .hw_cfg(hw_cfg), .rf_req(rf_req),
    .rf_grant(rf_grant), .ser_req(ser_req), .ser_grant(ser_grant), .host_evt(host_evt),
    .wait_timeout(wait_timeout), .host_state(host_state), .irq_src(irq_src),
    .irq_ack(irq_ack), .host_interrupt_request_n_o(pin_o),
    .host_interrupt_request_n_oe(pin_oe));
  tsa_host_model i_host (.mclk(mclk), .rst_b(rst_b), .irq_pin_oe(pin_oe), .irq_ack(irq_ack));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Byte port and reload helpers
  task automatic wrb(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk) {sa_addr, sa_wdata, sa_wr} <= {a, d, 1'b1};
    @(posedge mclk) sa_wr <= 1'b0;
  endtask : wrb
  task automatic rdb(input logic [8:0] a, input logic [7:0] exp);
    @(posedge mclk) sa_addr <= a;
    @(posedge mclk) #1 chk("byte read", 16'(exp), 16'(sa_rdata));
  endtask : rdb
  task automatic reload();
    @(posedge mclk) self_reset <= 1'b1;
    @(posedge mclk) self_reset <= 1'b0;
    @(posedge mclk) #1;
  endtask : reload
  task automatic acc(input logic rf, input logic [4:0] b, input logic e, input logic w,
                     input logic exp);
    @(posedge mclk) if (rf) rf_req <= {1'b1, b, e, w}; else ser_req <= {1'b1, b, e, w};
    @(posedge mclk) {rf_req, ser_req} <= '0;
    #1 chk(rf ? "rf grant" : "serial grant", 16'(exp), 16'(rf ? rf_grant : ser_grant));
  endtask : acc
  task automatic t_defaults();
    for (int i = 0; i < 12; i++) rdb(RF_RO_OFF + 9'(i), 8'h00);
    rdb(SYSTEM_CODE_OFF, 8'haa);
    rdb(SYSTEM_CODE_OFF + 9'h1, 8'hff);
    chk("system code", 16'haaff, hw_cfg.system_code_bytes);
    chk("slave addr", 16'h54, 16'(hw_cfg.host_slave_address));
    chk("protocol", 16'h0, 16'(hw_cfg.rf_protocol_select));
    chk("id source", 16'h0, 16'(hw_cfg.identifier_source_select));
    wrb(9'h0f0, 8'h5a);
    rdb(9'h0f0, 8'h00);
    $display("test defaults done");
  endtask : t_defaults
  // Four blocks carry the four lock and read-only combinations
  task automatic t_maps();
    logic [4:0] blk [4] = '{5'd0, 5'd9, 5'd18, 5'd26};
    logic ok;
    wrb(9'h1f1, 8'h02);
    wrb(9'h1f3, 8'h04);
    wrb(9'h1fa, 8'h04);
    wrb(9'h1fb, 8'h04);
    for (int c = 0; c < 4; c++) for (int m = 0; m < 4; m++) begin
      ok = c == 0 ? 1'b1 : c == 1 ? m[1] : c == 2 ? !m[0] : m[1] | !m[0];
      acc(1'b1, blk[c], m[1], m[0], ok);
    end
    acc(1'b1, 5'd27, 1'b0, 1'b1, 1'b1);
    wrb(9'h1f6, 8'h04);
    acc(1'b0, 5'd18, 1'b0, 1'b1, 1'b0);
    acc(1'b0, 5'd18, 1'b0, 1'b0, 1'b1);
    acc(1'b0, 5'd26, 1'b0, 1'b1, 1'b1);
    @(posedge mclk) cfg_valid <= 1'b0;
    acc(1'b1, 5'd18, 1'b0, 1'b1, 1'b1);
    @(posedge mclk) cfg_valid <= 1'b1;
    $display("test maps done");
  endtask : t_maps
  task automatic t_hw();
    wrb(HW_ONE_OFF + 9'h1, 8'h23);
    chk("slave addr", 16'h54, 16'(hw_cfg.host_slave_address));
    reload();
    chk("slave addr", 16'h23, 16'(hw_cfg.host_slave_address));
    for (int p = 0; p < 4; p++) begin
      wrb(HW_ONE_OFF, {2'b00, 2'(p), 3'b000, p[0]});
      reload();
      chk("protocol", p == 3 ? 16'h0 : 16'(p), 16'(hw_cfg.rf_protocol_select));
      chk("id source", 16'(p[0]), 16'(hw_cfg.identifier_source_select));
    end
    wrb(SYSTEM_CODE_OFF, 8'h12);
    @(posedge mclk) cfg_valid <= 1'b0;
    reload();
    chk("slave addr", 16'h54, 16'(hw_cfg.host_slave_address));
    chk("system code", 16'haaff, hw_cfg.system_code_bytes);
    @(posedge mclk) cfg_valid <= 1'b1;
    reload();
    chk("system code", 16'h12ff, hw_cfg.system_code_bytes);
    $display("test hardware settings done");
  endtask : t_hw
  // Length of one wait, from entry to the timeout pulse
  task automatic wt(input logic [7:0] ev, input int e, input int base);
    int n;
    @(posedge mclk) host_evt <= ev;
    @(posedge mclk) host_evt <= '0;
    for (n = 0; n < 2000 && wait_timeout !== 1'b1; n++) @(posedge mclk) #1;
    if (n == 2000) begin
      n_fail++;
      wrap_up();
    end
    chk("wait early", 16'h1, 16'(n >= (2 ** e - 1) * base));
    chk("wait late", 16'h1, 16'(n <= 2 ** e * base + 3));
    chk("state", 16'h01, 16'(host_state));
  endtask : wt
  task automatic t_waits();
    wrb(TUNNEL_OFF, 8'h91);
    wrb(HW_TWO_OFF, 8'h40);
    reload();
    wt(8'h80, 4, TB);
    wt(8'h20, 1, TB);
    wt(8'h08, 1, CB);
    wt(8'h02, 0, RB);
    wrb(TUNNEL_OFF, 8'h9d);
    reload();
    wt(8'h20, 7, TB);
    @(posedge mclk) host_evt <= 8'h80;
    @(posedge mclk) host_evt <= 8'h40;
    @(posedge mclk) host_evt <= '0;
    #1 chk("state", 16'h01, 16'(host_state));
    $display("test waits done");
  endtask : t_waits
  // Characters every six cycles keep the inter-character wait alive
  task automatic t_char();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 30; i++) begin
      @(posedge mclk) host_evt <= (i % 6 == 0) ? 8'h08 : 8'h00;
      #1 seen = seen | wait_timeout;
    end
    chk("char timeout", 16'h0, 16'(seen));
    chk("state", 16'h08, 16'(host_state));
    @(posedge mclk) host_evt <= 8'h04;
    @(posedge mclk) host_evt <= '0;
    #1 chk("state", 16'h01, 16'(host_state));
    $display("test characters done");
  endtask : t_char
  // Every select code against every source
  task automatic t_irq();
    logic exp;
    int n;
    for (int s = 0; s < 8; s++) begin
      wrb(HW_TWO_OFF, 8'h40 | 8'(s));
      reload();
      for (int q = 0; q < 4; q++) begin
        exp = q == 3 ? 1'b1 : q == 2 ? s[2:1] == 2'b10 : q == 1 ? s[2:1] == 2'b11 : s[0];
        @(posedge mclk) irq_src <= 4'(1 << q);
        @(posedge mclk) irq_src <= '0;
        @(posedge mclk) #1 chk("irq pin", 16'(exp), 16'(pin_oe));
        for (n = 0; n < 20 && pin_oe !== 1'b0; n++) @(posedge mclk) #1;
        chk("irq cleared", 16'h0, 16'(pin_oe));
      end
    end
    $display("test interrupts done");
  endtask : t_irq
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_defaults();
    t_maps();
    t_hw();
    t_waits();
    t_char();
    t_irq();
    wrap_up();
  end
endmodule : tsa_config_test

// [sim/tsa_host_model.sv]
// Host CPU stand-in that acknowledges the interrupt pin
module tsa_host_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Interrupt handshake
  input  wire logic irq_pin_oe,
  output logic      irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r;
  // Service latency of a few cycles, one ack per interrupt
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= 3'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= irq_pin_oe && cnt_r == 3'h2;
      cnt_r   <= !irq_pin_oe ? 3'h0 : (cnt_r == 3'h4 ? cnt_r : cnt_r + 3'h1);
    end
  end
endmodule : tsa_host_model
